// ==== rtl/acd_params.svh ====
// Function
// - each comparator has its own bias speed, setting delay, power and start-up
// - per comparator filter length: none, three-sample or five-sample majority
// - filtered output changes only when N/2+1 of last N samples agree
// - filter takes one raw sample per filter sample clock cycle
// - continuous: first output after N samples, then one per sample cycle
// - single-shot with filter completes only after the Nth sample
// - pin output carries raw result or synchronised filtered result
// - swap exchanges comparator inputs and inverts the result
// - three interrupt sources: two comparators by their condition, window by its field
// - each source has a flag; enable-set and enable-clear writes control its enable
// - request active while flag and enable both set
// - all requests ORed into one output; flags register shows the cause
// - comparator and window events copy state (window: inside) while output enable and unit enable are one
// - enabled input event starts a single-shot measurement; any event triggers
// - comparison after start-up; window mode starts both comparators together
// - standby-run bit zero powers comparator off in standby; one keeps running
// - with standby-run, enabled interrupts wake; sleep starts only from events
// - continuous sleep: unfiltered, clock requested only when a flag sets or wake is requested
// - single-shot sleep: event starts clock and comparator, stops after one comparison
// - reset, enables and window control take effect after synchronisation
// - synchronised bits read back at once; pending flag clears on effect
// - soft reset restores all registers, overrides the write, self-clears
`ifndef ACD_PARAMS_SVH
`define ACD_PARAMS_SVH

`define ACD_OFF_CTRL     8'h00
`define ACD_OFF_START    8'h04
`define ACD_OFF_EVCTRL   8'h08
`define ACD_OFF_IEN_CLR  8'h0C
`define ACD_OFF_IEN_SET  8'h10
`define ACD_OFF_FLAGS    8'h14
`define ACD_OFF_STATUS   8'h18
`define ACD_OFF_WINDOW_CONTROL  8'h1C
`define ACD_OFF_FIRST_COMPARATOR_SRC    8'h20
`define ACD_OFF_SECOND_COMPARATOR_SRC    8'h24

`define ACD_CTRL_SWRST   0
`define ACD_CTRL_EN      1
`define ACD_EV_EO        1:0
`define ACD_EV_WEO       4
`define ACD_EV_EI        9:8
`define ACD_ST_STATE     1:0
`define ACD_ST_WSTATE    5:4
`define ACD_ST_READY     9:8
`define ACD_ST_SYNC      15
`define ACD_WC_EN        0
`define ACD_WC_SEL       2:1
`define ACD_CC_EN        0
`define ACD_CC_SINGLE    1
`define ACD_CC_SPEED     3:2
`define ACD_CC_RUNSTBY   4
`define ACD_CC_INTSEL    6:5
`define ACD_CC_SWAP      15
`define ACD_CC_OUT       17:16
`define ACD_CC_FLEN      26:24

`define ACD_RST_WORD     32'h0000_0000
`define ACD_CLK_NS       4
`define ACD_SU_NS_0      800
`define ACD_SU_NS_1      400
`define ACD_SU_NS_2      200
`define ACD_SU_NS_3      100
`define ACD_SYNC_CYC     3'h3

`endif

// ==== rtl/acd_pkg.sv ====
package acd_pkg;

	typedef enum logic [1:0]
	{
		ACD_IDLE    = 2'b00,
		ACD_STARTUP = 2'b01,
		ACD_RUN     = 2'b10
	} acd_phase_t;

	typedef struct packed {
		logic                  hready;
		logic [31:0]           rdata;
		logic                  wr_pend;
		logic [7:0]            wr_addr;
		logic                  swrst;
		logic                  blk_en;
		logic                  blk_en_eff;
		logic [2:0]            sync_cnt;
		logic [1:0]            cen;
		logic [1:0]            cen_eff;
		logic [1:0]            single;
		logic [1:0]            keep_run;
		logic [1:0]            swap;
		logic [1:0][1:0]       speed;
		logic [1:0][1:0]       intsel;
		logic [1:0][1:0]       outsel;
		logic [1:0][2:0]       flen;
		logic                  win_en;
		logic                  win_en_eff;
		logic [1:0]            wsel;
		logic [1:0]            wsel_eff;
		logic [1:0]            eo;
		logic                  weo;
		logic [1:0]            ei;
		logic [2:0]            ien;
		logic [2:0]            flag;
		acd_phase_t [1:0]      ph;
		logic [1:0][7:0]       cnt;
		logic [1:0][4:0]       hist;
		logic [1:0][2:0]       nsamp;
		logic [1:0]            state;
		logic [1:0]            ready;
		logic [1:0]            wstate;
		logic [1:0]            pwr;
		logic                  irq;
		logic [1:0]            ev_comp;
		logic                  ev_win;
		logic [1:0]            pin;
		logic                  wake;
		logic                  clk_req;
	} acd_state_t;

endpackage

// ==== rtl/acd_top.sv ====
// The AHB-Lite register port and the placing of the registers are this design's own decisions.
`timescale 1ns/10ps
`include "acd_params.svh"

module acd_top
(
	// ahb-lite slave
	input  wire logic              hclk,
	input  wire logic              hresetn,
	input  wire logic              hsel,
	input  wire logic [31:0]       haddr,
	input  wire logic [1:0]        htrans,
	input  wire logic              hwrite,
	input  wire logic [2:0]        hsize,
	input  wire logic [31:0]       hwdata,
	input  wire logic              hready,
	output logic                   hreadyout,
	output logic                   hresp,
	output logic [31:0]            hrdata,
	// analog front end
	input  wire logic [1:0]        comp_raw,
	output logic [1:0]             comp_power_en,
	output logic [1:0]             comp_input_swap,
	output logic [3:0]             comp_bias_speed,
	output logic [1:0]             comparator_out_pin,
	// filter sample clock, as a one-cycle tick
	input  wire logic              filter_sample_tick,
	// event network
	input  wire logic [1:0]        comp_event_in,
	output logic [1:0]             comp_event_out,
	output logic                   window_event_out,
	// power manager and interrupt
	input  wire logic              sleep_active,
	output logic                   irq,
	output logic                   wake_req,
	output logic                   dig_clk_req
);
	import acd_pkg::*;

	localparam acd_state_t ACD_RST_S =
		acd_state_t'({1'b1, {($bits(acd_state_t) - 1){1'b0}}});

	acd_state_t q;
	acd_state_t d;
	logic [31:0] wdat;
	logic [31:0] rword;
	logic [1:0]  swstart;
	logic [1:0]  trig;
	logic [1:0]  act;
	logic [1:0]  res;
	logic [1:0]  upd;
	logic [1:0]  nv;
	logic [1:0]  eoc;
	logic [2:0]  fset;
	logic [2:0]  fclr;
	logic [2:0]  nn;
	logic [4:0]  hn;
	logic [1:0]  wn;
	logic        ci;

	////////////////////////////////////////////////////////////////////////
	// helpers

	function automatic logic [7:0] startup_cyc(input logic [1:0] sp);
		int ns;
		unique case (sp)
			2'b00: ns = `ACD_SU_NS_0;
			2'b01: ns = `ACD_SU_NS_1;
			2'b10: ns = `ACD_SU_NS_2;
			2'b11: ns = `ACD_SU_NS_3;
		endcase
		startup_cyc = 8'((ns + `ACD_CLK_NS - 1) / `ACD_CLK_NS);
	endfunction

	function automatic logic [2:0] flen_n(input logic [2:0] f);
		unique case (f)
			3'h1:    flen_n = 3'h3;
			3'h2:    flen_n = 3'h5;
			default: flen_n = 3'h1;
		endcase
	endfunction

	// vote needs n/2+1 agreeing samples
	function automatic logic maj(input logic [4:0] h, input logic [2:0] n);
		logic [2:0] c;
		c = 3'(h[0]) + 3'(h[1]) + 3'(h[2]);
		if (n == 3'h5)
			maj = (3'(c + 3'(h[3]) + 3'(h[4])) >= 3'h3);
		else if (n == 3'h3)
			maj = (c >= 3'h2);
		else
			maj = h[0];
	endfunction

	// 00 above, 01 inside, 10 below; first_comparator_src upper limit, second_comparator_src lower
	function automatic logic [1:0] wcode(input logic s0, input logic s1);
		if (s0)
			wcode = 2'h0;
		else if (s1)
			wcode = 2'h1;
		else
			wcode = 2'h2;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// next state

	always_comb
	begin
		d = q;
		wdat = hwdata;
		rword = 32'h0000_0000;
		swstart = 2'b00;
		trig = 2'b00;
		act = 2'b00;
		res = 2'b00;
		upd = 2'b00;
		nv = q.state;
		eoc = 2'b00;
		fset = 3'b000;
		fclr = 3'b000;
		nn = 3'h1;
		hn = 5'h00;
		wn = 2'h0;
		ci = 1'b0;

		// address phase: zero wait states, read word captured now
		d.hready = 1'b1;
		d.wr_pend = 1'b0;
		d.rdata = 32'h0000_0000;
		if (hsel && htrans[1] && hready)
		begin
			d.wr_pend = hwrite;
			d.wr_addr = haddr[7:0];
			unique case (haddr[7:0])
				`ACD_OFF_CTRL:
				begin
					rword[`ACD_CTRL_SWRST] = q.swrst;
					rword[`ACD_CTRL_EN] = q.blk_en;
				end
				`ACD_OFF_EVCTRL:
				begin
					rword[`ACD_EV_EO] = q.eo;
					rword[`ACD_EV_WEO] = q.weo;
					rword[`ACD_EV_EI] = q.ei;
				end
				`ACD_OFF_IEN_CLR, `ACD_OFF_IEN_SET:
					rword[2:0] = q.ien;
				`ACD_OFF_FLAGS:
					rword[2:0] = q.flag;
				`ACD_OFF_STATUS:
				begin
					rword[`ACD_ST_STATE] = q.state;
					rword[`ACD_ST_WSTATE] = q.wstate;
					rword[`ACD_ST_READY] = q.ready;
					rword[`ACD_ST_SYNC] = q.swrst | (q.sync_cnt != 3'h0);
				end
				`ACD_OFF_WINDOW_CONTROL:
				begin
					rword[`ACD_WC_EN] = q.win_en;
					rword[`ACD_WC_SEL] = q.wsel;
				end
				`ACD_OFF_FIRST_COMPARATOR_SRC, `ACD_OFF_SECOND_COMPARATOR_SRC:
				begin
					ci = haddr[2];
					rword[`ACD_CC_EN] = q.cen[ci];
					rword[`ACD_CC_SINGLE] = q.single[ci];
					rword[`ACD_CC_SPEED] = q.speed[ci];
					rword[`ACD_CC_RUNSTBY] = q.keep_run[ci];
					rword[`ACD_CC_INTSEL] = q.intsel[ci];
					rword[`ACD_CC_SWAP] = q.swap[ci];
					rword[`ACD_CC_OUT] = q.outsel[ci];
					rword[`ACD_CC_FLEN] = q.flen[ci];
				end
				default:
					rword = `ACD_RST_WORD;
			endcase
			if (!hwrite)
				d.rdata = rword;
		end

		// count down first so a write landing on the last count still reloads
		if (q.sync_cnt != 3'h0)
			d.sync_cnt = 3'(q.sync_cnt - 3'h1);

		// data phase write
		if (q.wr_pend && !q.swrst)
		begin
			unique case (q.wr_addr)
				`ACD_OFF_CTRL:
				begin
					d.sync_cnt = `ACD_SYNC_CYC;
					if (wdat[`ACD_CTRL_SWRST])
						d.swrst = 1'b1;
					else
						d.blk_en = wdat[`ACD_CTRL_EN];
				end
				`ACD_OFF_START:
					swstart = wdat[1:0];
				`ACD_OFF_EVCTRL:
				begin
					d.eo = wdat[`ACD_EV_EO];
					d.weo = wdat[`ACD_EV_WEO];
					d.ei = wdat[`ACD_EV_EI];
				end
				`ACD_OFF_IEN_CLR:
					d.ien = q.ien & ~wdat[2:0];
				`ACD_OFF_IEN_SET:
					d.ien = q.ien | wdat[2:0];
				`ACD_OFF_FLAGS:
					fclr = wdat[2:0];
				`ACD_OFF_WINDOW_CONTROL:
				begin
					d.sync_cnt = `ACD_SYNC_CYC;
					d.win_en = wdat[`ACD_WC_EN];
					d.wsel = wdat[`ACD_WC_SEL];
				end
				`ACD_OFF_FIRST_COMPARATOR_SRC, `ACD_OFF_SECOND_COMPARATOR_SRC:
				begin
					ci = q.wr_addr[2];
					d.sync_cnt = `ACD_SYNC_CYC;
					d.cen[ci] = wdat[`ACD_CC_EN];
					d.single[ci] = wdat[`ACD_CC_SINGLE];
					d.speed[ci] = wdat[`ACD_CC_SPEED];
					d.keep_run[ci] = wdat[`ACD_CC_RUNSTBY];
					d.intsel[ci] = wdat[`ACD_CC_INTSEL];
					d.swap[ci] = wdat[`ACD_CC_SWAP];
					d.outsel[ci] = wdat[`ACD_CC_OUT];
					d.flen[ci] = wdat[`ACD_CC_FLEN];
				end
				default:
					fclr = 3'b000;
			endcase
		end

		// synchronised bits land only when the counter expires
		if (q.sync_cnt == 3'h1)
		begin
			d.blk_en_eff = q.blk_en;
			d.cen_eff = q.cen;
			d.win_en_eff = q.win_en;
			d.wsel_eff = q.wsel;
		end

		// triggers; software start is ignored while asleep
		trig = (q.ei & comp_event_in) | (sleep_active ? 2'b00 : swstart);
		if (q.win_en_eff && (trig != 2'b00))
			trig = 2'b11;

		for (int i = 0; i < 2; i++)
		begin
			res[i] = comp_raw[i] ^ q.swap[i];
			act[i] = q.blk_en_eff & q.cen_eff[i] & ~(sleep_active & ~q.keep_run[i]);
			nn = flen_n(q.flen[i]);
			if (sleep_active && !q.single[i])
				nn = 3'h1;
			if (!act[i])
			begin
				d.ph[i] = ACD_IDLE;
				d.pwr[i] = 1'b0;
				d.hist[i] = 5'h00;
				d.nsamp[i] = 3'h0;
			end
			else
			begin
				unique case (q.ph[i])
					ACD_IDLE:
						if (!q.single[i] || trig[i])
						begin
							d.ph[i] = ACD_STARTUP;
							d.cnt[i] = startup_cyc(q.speed[i]);
							d.hist[i] = 5'h00;
							d.nsamp[i] = 3'h0;
							d.pwr[i] = 1'b1;
							d.ready[i] = 1'b0;
						end
					ACD_STARTUP:
						if (q.cnt[i] <= 8'h01)
							d.ph[i] = ACD_RUN;
						else
							d.cnt[i] = 8'(q.cnt[i] - 8'h01);
					ACD_RUN:
						if (filter_sample_tick)
						begin
							hn = {q.hist[i][3:0], res[i]};
							d.hist[i] = hn;
							if (q.nsamp[i] < nn)
								d.nsamp[i] = 3'(q.nsamp[i] + 3'h1);
							if (3'(q.nsamp[i] + 3'h1) >= nn)
							begin
								upd[i] = 1'b1;
								nv[i] = maj(hn, nn);
								if (q.single[i])
								begin
									eoc[i] = 1'b1;
									d.ready[i] = 1'b1;
									d.ph[i] = ACD_IDLE;
									d.pwr[i] = 1'b0;
								end
							end
						end
					default:
						d.ph[i] = ACD_IDLE;
				endcase
			end
			d.state[i] = nv[i];
			if (upd[i])
			begin
				unique case (q.intsel[i])
					2'h0: fset[i] = nv[i] ^ q.state[i];
					2'h1: fset[i] = nv[i] & ~q.state[i];
					2'h2: fset[i] = ~nv[i] & q.state[i];
					2'h3: fset[i] = eoc[i];
				endcase
			end
		end

		// window state and interrupt
		wn = wcode(d.state[0], d.state[1]);
		if (q.win_en_eff)
		begin
			d.wstate = wn;
			if (wn != q.wstate)
			begin
				unique case (q.wsel_eff)
					2'h0: fset[2] = (wn == 2'h0);
					2'h1: fset[2] = (wn == 2'h1);
					2'h2: fset[2] = (wn == 2'h2);
					2'h3: fset[2] = (wn != 2'h1);
				endcase
			end
		end

		// a set in the clearing cycle is kept
		d.flag = (q.flag & ~fclr) | fset;

		// soft reset lands last and wipes everything
		if (q.sync_cnt == 3'h1 && q.swrst)
		begin
			d = ACD_RST_S;
		end

		d.irq = |(d.flag & d.ien);
		d.ev_comp = d.state & d.eo & d.cen_eff;
		d.ev_win = (d.wstate == 2'h1) & d.weo & d.win_en_eff;
		for (int i = 0; i < 2; i++)
		begin
			unique case (d.outsel[i])
				2'h1:    d.pin[i] = comp_raw[i] ^ d.swap[i];
				2'h2:    d.pin[i] = d.state[i];
				default: d.pin[i] = 1'b0;
			endcase
		end
		d.wake = d.irq & sleep_active & (|d.keep_run);
		// clock kept only while a sleeping single-shot comparison runs, a flag lands or wake is requested
		d.clk_req = sleep_active &
			((|(d.single & d.pwr)) | (fset != 3'b000) | d.wake);
	end

	////////////////////////////////////////////////////////////////////////
	// state register

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			q <= ACD_RST_S;
		else
			q <= d;
	end

	assign hreadyout = q.hready;
	assign hresp = 1'b0;
	assign hrdata = q.rdata;
	assign comp_power_en = q.pwr;
	assign comp_input_swap = q.swap;
	assign comp_bias_speed = q.speed;
	assign comparator_out_pin = q.pin;
	assign comp_event_out = q.ev_comp;
	assign window_event_out = q.ev_win;
	assign irq = q.irq;
	assign wake_req = q.wake;
	assign dig_clk_req = q.clk_req;

endmodule

// ==== verification/acd_sva.sv ====
`timescale 1ns/10ps
////////////////////////////////
module acd_sva
(
	// bus
	input wire logic        hclk,
	input wire logic        hresetn,
	input wire logic        hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic        hready,
	input wire logic [31:0] hwdata,
	input wire logic        hreadyout,
	input wire logic        hresp,
	input wire logic [31:0] hrdata,
	// block side
	input wire logic [1:0]  comp_input_swap,
	input wire logic [3:0]  comp_bias_speed,
	input wire logic [1:0]  comp_power_en,
	input wire logic        sleep_active,
	input wire logic        irq,
	input wire logic        wake_req,
	input wire logic        dig_clk_req
);
	logic       rd_q;
	logic       wr_q;
	logic       ctl_q;
	logic [3:0] age_q;
	wire        srst = wr_q && ctl_q && hwdata[0];
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	// age of the last write; config outputs may only move shortly after one
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			rd_q  <= 1'b0;
			wr_q  <= 1'b0;
			ctl_q <= 1'b0;
			age_q <= 4'hF;
		end
		else
		begin
			rd_q  <= hsel && htrans[1] && hready && !hwrite;
			wr_q  <= hsel && htrans[1] && hready && hwrite;
			ctl_q <= haddr[7:0] == 8'h00;
			age_q <= wr_q ? 4'h0 : (age_q == 4'hF ? age_q : age_q + 4'h1);
		end
	end
	////////////////////////////////
	hready_high_a: assert property (hreadyout == 1'b1)
		else $error("hreadyout low");
	resp_okay_a: assert property (hresp == 1'b0)
		else $error("hresp not okay");
	rdata_idle_a: assert property (!rd_q |-> hrdata == 32'h0)
		else $error("hrdata outside data phase");
	speed_by_write_a: assert property ($changed(comp_bias_speed) |-> age_q < 4'h8)
		else $error("bias speed moved without write");
	swap_by_write_a: assert property ($changed(comp_input_swap) |-> age_q < 4'h8)
		else $error("swap moved without write");
	irq_hold_a: assert property ($fell(irq) |-> age_q < 4'h8)
		else $error("irq dropped without write");
	wake_sleep_a: assert property (wake_req |-> $past(sleep_active))
		else $error("wake outside sleep");
	clk_req_sleep_a: assert property (dig_clk_req |-> sleep_active || $past(sleep_active))
		else $error("clock request outside sleep");
	soft_reset_a: assert property (srst |-> ##[1:6] (comp_power_en == 2'h0 && !irq))
		else $error("soft reset left state");
	cover property ($rose(irq));
	cover property ($rose(wake_req));
	cover property (srst);
endmodule

// ==== verification/acd_far_model.sv ====
`timescale 1ns/10ps
////////////////////////////////
module acd_far_model
#(
	parameter int TICK_DIV = 8
)
(
	// clock
	input  wire logic       hclk,
	// bench requests
	input  wire logic [1:0] lvl,
	input  wire logic [1:0] ev_req,
	// to block
	output logic      [1:0] comp_raw,
	output logic            filter_sample_tick,
	output logic      [1:0] comp_event_in
);
	int div_q;
	initial
	begin
		div_q = 0;
		comp_raw = 2'h0;
		filter_sample_tick = 1'b0;
		comp_event_in = 2'h0;
	end
	// tick far apart so filter latency never spans two samples
	always @(posedge hclk)
	begin
		div_q <= (div_q == TICK_DIV - 1) ? 0 : div_q + 1;
		filter_sample_tick <= div_q == 0;
		comp_raw <= lvl;
		comp_event_in <= ev_req;
	end
endmodule

// ==== verification/tb_top.sv ====
`timescale 1ns/10ps
`include "acd_params.svh"
////////////////////////////////
module tb_top;
	logic        hclk;
	logic        hresetn = 1'b0;
	logic        hsel = 1'b0;
	logic        hwrite = 1'b0;
	logic        sleep_active = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] rd;
	logic [1:0]  htrans = 2'h0;
	logic [1:0]  lvl = 2'h0;
	logic [1:0]  ev_req = 2'h0;
	logic [2:0]  hsize = 3'h2;
	wire         hreadyout, hresp, irq, wake_req, dig_clk_req;
	wire         window_event_out, filter_sample_tick;
	wire  [31:0] hrdata;
	wire  [1:0]  comp_raw, comp_power_en, comp_input_swap;
	wire  [1:0]  comparator_out_pin, comp_event_out, comp_event_in;
	wire  [3:0]  comp_bias_speed;
	int          errors = 0;
	int          cmp_count = 0;
	acd_top uut
	(
		.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
		.hready(hreadyout), .hreadyout, .hresp, .hrdata, .comp_raw,
		.comp_power_en, .comp_input_swap, .comp_bias_speed, .comparator_out_pin,
		.filter_sample_tick, .comp_event_in, .comp_event_out, .window_event_out,
		.sleep_active, .irq, .wake_req, .dig_clk_req
	);
	acd_far_model far
	(
		.hclk, .lvl, .ev_req, .comp_raw, .filter_sample_tick, .comp_event_in
	);
	////////////////////////////////
	task automatic conclude();
		$display("checks %0d errors %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		cmp_count++;
		if (got !== exp)
		begin
			errors++;
			$display("CHECK FAILED %s exp %h got %h", what, exp, got);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge hclk);
	endtask
	task automatic wait_hi(input logic tick);
		int n;
		n = 0;
		do
		begin
			@(posedge hclk);
			n++;
			if (n > 40)
			begin
				errors++;
				conclude();
			end
		end
		while ((tick ? filter_sample_tick : hreadyout) !== 1'b1);
	endtask
	// requests change only right after an edge and hold until hready
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		hsel   <= 1'b1;
		haddr  <= {24'h0, a};
		hwrite <= w;
		htrans <= 2'h2;
		wait_hi(1'b0);
		hsel   <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		wait_hi(1'b0);
		rd = hrdata;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask
	task automatic rdc(input string n, input logic [7:0] a, input logic [31:0] m,
		input logic [31:0] v);
		bus(1'b0, a, 32'h0);
		chk(n, v, rd & m);
	endtask
	task automatic ticks(input int k);
		repeat (k) wait_hi(1'b1);
	endtask
	////////////////////////////////
	task automatic sc_sync();
		wr(`ACD_OFF_CTRL, 32'h2);
		rdc("pending", `ACD_OFF_STATUS, 32'h8000, 32'h8000);
		rdc("enable", `ACD_OFF_CTRL, 32'h3, 32'h2);
		cyc(6);
		rdc("settled", `ACD_OFF_STATUS, 32'h8000, 32'h0);
	endtask
	task automatic sc_filter();
		wr(`ACD_OFF_EVCTRL, 32'h1);
		wr(`ACD_OFF_IEN_SET, 32'h1);
		wr(`ACD_OFF_FIRST_COMPARATOR_SRC, 32'h0102_002D);
		cyc(60);
		ticks(1);
		lvl <= 2'h1;
		ticks(1);
		lvl <= 2'h0;
		ticks(3);
		chk("lone sample", 32'h0, 32'(comparator_out_pin[0]));
		lvl <= 2'h1;
		ticks(1);
		cyc(4);
		chk("one of three", 32'h0, 32'(comparator_out_pin[0]));
		ticks(1);
		cyc(4);
		chk("two of three", 32'h1, 32'(comparator_out_pin[0]));
		chk("rise irq", 32'h1, 32'(irq));
		chk("event out", 32'h1, 32'(comp_event_out));
		rdc("flags", `ACD_OFF_FLAGS, 32'h7, 32'h1);
		wr(`ACD_OFF_IEN_CLR, 32'h1);
		cyc(2);
		chk("masked", 32'h0, 32'(irq));
		wr(`ACD_OFF_IEN_SET, 32'h1);
		cyc(2);
		chk("unmasked", 32'h1, 32'(irq));
		wr(`ACD_OFF_FLAGS, 32'h1);
		cyc(2);
		chk("cleared", 32'h0, 32'(irq));
	endtask
	task automatic sc_swap();
		wr(`ACD_OFF_SECOND_COMPARATOR_SRC, 32'h0001_800C);
		cyc(2);
		chk("swap", 32'h2, 32'(comp_input_swap));
		chk("speed", 32'hF, 32'(comp_bias_speed));
		wr(`ACD_OFF_SECOND_COMPARATOR_SRC, 32'h0001_800D);
		cyc(40);
		lvl <= 2'h3;
		cyc(3);
		chk("raw high", 32'h0, 32'(comparator_out_pin[1]));
		lvl <= 2'h1;
		cyc(3);
		chk("raw low", 32'h1, 32'(comparator_out_pin[1]));
	endtask
	task automatic sc_single();
		int n;
		wr(`ACD_OFF_FIRST_COMPARATOR_SRC, 32'h0);
		wr(`ACD_OFF_SECOND_COMPARATOR_SRC, 32'h0);
		wr(`ACD_OFF_SECOND_COMPARATOR_SRC, 32'h1F);
		wr(`ACD_OFF_FIRST_COMPARATOR_SRC, 32'h7F);
		wr(`ACD_OFF_EVCTRL, 32'h110);
		wr(`ACD_OFF_WINDOW_CONTROL, 32'h1);
		wr(`ACD_OFF_FLAGS, 32'h7);
		sleep_active <= 1'b1;
		lvl <= 2'h2;
		wr(`ACD_OFF_START, 32'h3);
		cyc(2);
		chk("sleep start", 32'h0, 32'(comp_power_en));
		ev_req <= 2'h1;
		cyc(1);
		ev_req <= 2'h0;
		cyc(3);
		chk("both on", 32'h3, 32'(comp_power_en));
		chk("clk req", 32'h1, 32'(dig_clk_req));
		n = 0;
		do
		begin
			bus(1'b0, `ACD_OFF_STATUS, 32'h0);
			n++;
		end
		while ((rd & 32'h300) !== 32'h300 && n < 100);
		chk("ready", 32'h300, rd & 32'h300);
		cyc(3);
		chk("power off", 32'h0, 32'(comp_power_en));
		chk("wake", 32'h1, 32'(wake_req));
		chk("win event", 32'h1, 32'(window_event_out));
		sleep_active <= 1'b0;
		wr(`ACD_OFF_START, 32'h2);
		cyc(2);
		chk("sw start", 32'h3, 32'(comp_power_en));
	endtask
	task automatic sc_swrst();
		wr(`ACD_OFF_CTRL, 32'h3);
		rdc("rst busy", `ACD_OFF_CTRL, 32'h1, 32'h1);
		cyc(6);
		rdc("ctrl", `ACD_OFF_CTRL, 32'hFFFF_FFFF, 32'h0);
		rdc("first_comparator_src", `ACD_OFF_FIRST_COMPARATOR_SRC, 32'hFFFF_FFFF, 32'h0);
		chk("irq off", 32'h0, 32'(irq));
	endtask
	////////////////////////////////
	initial
	begin
		hclk = 1'b0;
		forever #2 hclk = ~hclk;
	end
	initial
	begin
		repeat (10) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		rdc("first_comparator_src rst", `ACD_OFF_FIRST_COMPARATOR_SRC, 32'hFFFF_FFFF, `ACD_RST_WORD);
		wr(8'h40, 32'hFFFF_FFFF);
		rdc("unmapped", 8'h40, 32'hFFFF_FFFF, 32'h0);
		sc_sync();
		sc_filter();
		sc_swap();
		sc_single();
		sc_swrst();
		conclude();
	end
endmodule
////////////////////////////////
bind acd_top acd_sva chk_i
(
	.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hready, .hwdata,
	.hreadyout, .hresp, .hrdata, .comp_input_swap, .comp_bias_speed,
	.comp_power_en, .sleep_active, .irq, .wake_req, .dig_clk_req
);
